// ### core/shdp_pkg.sv
// Operation
// - The block is started only by the device's internal power-on reset, with no reset pin of its own.
// - While chip select is high the serial output carries the low-active interrupt state.
// - The serial output is driven at all times and is never released.
// - Power-on reset clears every register bit to zero except the step clock prescaler.
// - Power-on reset loads the step clock prescaler with 15.
// - Each transaction is one 32-bit datagram; shorter frames are dropped and longer ones keep their last 32 bits.
// - The port is a 32-bit shift register taking one input bit on each serial clock rise.
// - On the chip select rise after 32 or more bits the whole shift register is copied into a holding buffer; the code drops it if it and the FIFO are full.
// - Read data is returned during the same datagram exchange.
// - Each output bit changes no sooner than four clocks after the serial clock falls.
// - Datagram bits travel most significant first in both directions.
// - Incoming bit 31 selects registers or RAM, 30..25 the address, 24 read, 23..0 data.
// - The reply holds eight status bits on top and 24 read data bits below.
package shdp_pkg;
    localparam int DGRAM_BITS = 32;
    localparam int STATUS_BITS = 8;
    localparam int DATA_BITS = 24;
    localparam int CNT_W = 6;
    localparam int RRS_BIT = 31;
    localparam int ADDR_MSB = 30;
    localparam int ADDR_LSB = 25;
    localparam int RW_BIT = 24;
    localparam int ADDR_W = 6;
    localparam int PRESC_W = 4;
    localparam int PRESC_LSB = 0;
    localparam int FIFO_DEPTH = 4;
    // Synchroniser lanes
    localparam int LANE_CS = 0;
    localparam int LANE_SCK = 1;
    localparam int LANE_SDI = 2;
    localparam int LANES = 3;
    localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
    localparam logic [CNT_W-1:0] CNT_ADDR_DONE = 6'h07;
    localparam logic [PRESC_W-1:0] PRESC_RESET = 4'hF;
    localparam logic [DGRAM_BITS-1:0] REG_RESET = 32'h00000000;
    localparam logic [ADDR_W-1:0] PRESC_ADDR_DEFAULT = 6'h01;
    localparam int CLK_PERIOD_NS = 20;
    localparam int OUT_MIN_CLKS = 4;
endpackage : shdp_pkg

// ### core/shdp_port.sv
`timescale 1ns/1ps
module shdp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic push;
    logic pop;

    assign in_ready_out = (count != (PW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out = mem[rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
            end
            count <= PW'(0) + (PW+1)'(count + (PW+1)'(push) - (PW+1)'(pop));
        end
    end

    fifo_bound_a: assert property (@(posedge clk_in) disable iff (rst_in)
        count <= (PW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : shdp_fifo

module shdp_port
    import shdp_pkg::*;
#(
    parameter logic [ADDR_W-1:0] PRESC_ADDR = PRESC_ADDR_DEFAULT
) (
    // Clock and power-on reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Host serial pins
    input wire logic host_chip_select_n_in,
    input wire logic host_sclk_in,
    input wire logic host_sdi_in,
    output logic irq_n_or_serial_out_out,
    // Device state sent back to the host
    input wire logic irq_status_n_in,
    input wire logic [STATUS_BITS-1:0] status_in,
    // Read port into registers and RAM
    output logic rd_req_out,
    output logic rd_ram_out,
    output logic [ADDR_W-1:0] rd_addr_out,
    input wire logic [DATA_BITS-1:0] rd_data_in,
    // Committed datagrams
    output logic dgram_valid_out,
    input wire logic dgram_ready_in,
    output logic [DGRAM_BITS-1:0] dgram_data_out,
    output logic dgram_overrun_out,
    // Step clock prescaler
    output logic [PRESC_W-1:0] step_clock_prescaler_out
);
    logic [LANES-1:0] sync1;
    logic [LANES-1:0] sync2;
    logic [LANES-1:0] sync3;
    logic [LANES-1:0] lvl;
    logic [LANES-1:0] agree;
    logic [LANES-1:0] chg;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic sck_fall_d;
    logic tx_started;
    logic stage_take;
    logic rd_load;
    logic [DGRAM_BITS-1:0] rx_shift;
    logic [DGRAM_BITS-1:0] tx_shift;
    logic [CNT_W-1:0] bit_cnt;
    logic [DGRAM_BITS-1:0] hold;
    logic hold_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [DGRAM_BITS-1:0] fifo_out_data;
    logic commit;

    // Three stages; a change counts once the last two agree
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync1 <= 3'h3;
            sync2 <= 3'h3;
            sync3 <= 3'h3;
            lvl <= 3'h3;
        end else begin
            sync1 <= {host_sdi_in, host_sclk_in, host_chip_select_n_in};
            sync2 <= sync1;
            sync3 <= sync2;
            lvl <= (lvl & ~agree) | (sync3 & agree);
        end
    end

    assign agree = ~(sync2 ^ sync3);
    assign chg = agree & (sync3 ^ lvl);
    assign cs_fall = chg[LANE_CS] && !sync3[LANE_CS];
    assign cs_rise = chg[LANE_CS] && sync3[LANE_CS];
    assign sck_rise = chg[LANE_SCK] && sync3[LANE_SCK] && !lvl[LANE_CS];
    assign sck_fall = chg[LANE_SCK] && !sync3[LANE_SCK] && !lvl[LANE_CS];
    assign commit = cs_rise && (bit_cnt == CNT_FULL);

    // Receive shifter and bit counter
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_shift <= REG_RESET;
            bit_cnt <= '0;
        end else if (cs_fall) begin
            bit_cnt <= '0;
        end else if (sck_rise) begin
            rx_shift <= {rx_shift[DGRAM_BITS-2:0], sync3[LANE_SDI]};
            if (bit_cnt != CNT_FULL) begin
                bit_cnt <= CNT_W'(bit_cnt + 1'b1);
            end
        end
    end

    // Address is known after seven bits, so the read goes out mid-frame with the eighth
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_req_out <= 1'b0;
            rd_ram_out <= 1'b0;
            rd_addr_out <= '0;
            rd_load <= 1'b0;
        end else begin
            rd_req_out <= sck_rise && (bit_cnt == CNT_ADDR_DONE) && sync3[LANE_SDI];
            // The read bit is still arriving, so the fields sit one place lower
            if (sck_rise && (bit_cnt == CNT_ADDR_DONE)) begin
                rd_ram_out <= rx_shift[RRS_BIT-DATA_BITS-1];
                rd_addr_out <= rx_shift[ADDR_MSB-DATA_BITS-1:ADDR_LSB-DATA_BITS-1];
            end
            rd_load <= rd_req_out;
        end
    end

    // Transmit shifter; the shift waits one extra clock to keep the output late enough
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_shift <= REG_RESET;
            sck_fall_d <= 1'b0;
            tx_started <= 1'b0;
        end else begin
            sck_fall_d <= sck_fall;
            if (cs_fall) begin
                tx_shift <= {status_in, DATA_BITS'(0)};
                tx_started <= 1'b0;
            end else if (rd_load) begin
                // Seven shifts are done by now, so the word lands just below the top
                tx_shift[DGRAM_BITS-2 -: DATA_BITS] <= rd_data_in;
            end else if (sck_fall_d) begin
                // The first fall keeps bit 31 on the pin; the host samples it at the next rise
                tx_started <= 1'b1;
                if (tx_started) begin
                    tx_shift <= {tx_shift[DGRAM_BITS-2:0], 1'b0};
                end
            end
        end
    end

    // Pin is always driven: interrupt while idle, reply bit while selected
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            irq_n_or_serial_out_out <= 1'b1;
        end else if (lvl[LANE_CS]) begin
            irq_n_or_serial_out_out <= irq_status_n_in;
        end else begin
            irq_n_or_serial_out_out <= tx_shift[DGRAM_BITS-1];
        end
    end

    // Holding buffer; a datagram that finds it occupied while the FIFO is full is dropped and flagged
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hold <= REG_RESET;
            hold_valid <= 1'b0;
            dgram_overrun_out <= 1'b0;
        end else begin
            dgram_overrun_out <= commit && hold_valid && !fifo_in_ready;
            if (commit && (!hold_valid || fifo_in_ready)) begin
                hold <= rx_shift;
                hold_valid <= 1'b1;
            end else if (fifo_in_ready) begin
                hold_valid <= 1'b0;
            end
        end
    end

    shdp_fifo #(
        .WIDTH(DGRAM_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(mclk_in),
        .rst_in(sys_rst_in),
        .in_valid_in(hold_valid),
        .in_ready_out(fifo_in_ready),
        .in_data_in(hold),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(stage_take),
        .out_data_out(fifo_out_data)
    );

    // Registered drain stage keeps outputs straight from flops; pop only when it loads
    assign stage_take = !dgram_valid_out || dgram_ready_in;

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dgram_valid_out <= 1'b0;
            dgram_data_out <= REG_RESET;
        end else if (stage_take) begin
            dgram_valid_out <= fifo_out_valid;
            dgram_data_out <= fifo_out_data;
        end
    end

    // Prescaler write decode; only this field starts nonzero
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            step_clock_prescaler_out <= PRESC_RESET;
        end else if (commit && !rx_shift[RRS_BIT] && !rx_shift[RW_BIT]
                     && rx_shift[ADDR_MSB:ADDR_LSB] == PRESC_ADDR) begin
            step_clock_prescaler_out <= rx_shift[PRESC_LSB +: PRESC_W];
        end
    end

    idle_irq_mux_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        lvl[LANE_CS] |=> irq_n_or_serial_out_out == $past(irq_status_n_in))
        else $error("idle output is not the interrupt state");
    late_output_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        sck_fall |=> $stable(irq_n_or_serial_out_out))
        else $error("output changed too soon after clock fall");
    rx_shift_in_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        sck_rise && !cs_fall |=> rx_shift[0] == $past(sync3[LANE_SDI]))
        else $error("input bit not shifted in");
    frame_commit_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        commit && !hold_valid |=> hold_valid && hold == $past(rx_shift))
        else $error("full datagram not committed");
    short_frame_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        cs_rise && bit_cnt != CNT_FULL && !hold_valid |=> !hold_valid)
        else $error("short frame committed");
    read_request_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        sck_rise && bit_cnt == CNT_ADDR_DONE && sync3[LANE_SDI] |=> rd_req_out)
        else $error("read request missing after address");
    read_load_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        rd_req_out && !sck_fall |=> ##1 tx_shift[DGRAM_BITS-2 -: DATA_BITS] == $past(rd_data_in))
        else $error("read data not loaded into reply");
    status_first_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        cs_fall |=> tx_shift[DGRAM_BITS-1:DATA_BITS] == $past(status_in))
        else $error("status byte not placed first");
    prescaler_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !$stable(step_clock_prescaler_out) |-> $past(commit))
        else $error("prescaler changed without a write");
endmodule : shdp_port

// ### tb/shdp_host.sv
`timescale 1ns/1ps
module shdp_host (
    // Device clock
    input wire logic mclk_in,
    // Serial pins
    output logic cs_n_out,
    output logic sclk_out,
    output logic sdi_out,
    input wire logic sdo_in
);
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b1;
        sdi_out = 1'b0;
    end
    task automatic clks(input int n);
        repeat (n) @(negedge mclk_in);
    endtask : clks
    // Eight clocks a phase, well clear of the four-clock minimum
    task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
        rx = 32'h00000000;
        clks(8);
        cs_n_out = 1'b0;
        clks(8);
        for (int i = nbits - 1; i >= 0; i--) begin
            sclk_out = 1'b0;
            sdi_out = tx[i % 32];
            clks(8);
            sclk_out = 1'b1;
            rx = {rx[30:0], sdo_in};
            clks(8);
        end
        cs_n_out = 1'b1;
        // Released data line shows the inverse, not a stale bit
        sdi_out = ~sdi_out;
    endtask : xfer
endmodule : shdp_host

// ### tb/tb_shdp_port.sv
`timescale 1ns/1ps
module tb_shdp_port
    import shdp_pkg::*;
();
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic cs_n, sclk, sdi, sdo, rd_req, rd_ram, dv, ovr;
    logic irq_n;
    logic ready;
    logic [7:0] status;
    logic [5:0] rd_addr;
    logic [23:0] rd_data;
    logic [31:0] dd, rx;
    logic [3:0] presc;
    logic [6:0] req_tag;
    logic [31:0] got[$];
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    int n_req = 0;
    int n_ovr = 0;
    int since_fall = 99;
    logic prev_sclk = 1'b1;
    logic prev_out = 1'b1;
    logic prev_cs = 1'b1;

    always #10 mclk_in = ~mclk_in;

    shdp_host host_u (.mclk_in(mclk_in), .cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi),
        .sdo_in(sdo));
    shdp_port #(.PRESC_ADDR(PRESC_ADDR_DEFAULT)) dut_u (.mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in), .host_chip_select_n_in(cs_n), .host_sclk_in(sclk),
        .host_sdi_in(sdi), .irq_n_or_serial_out_out(sdo), .irq_status_n_in(irq_n),
        .status_in(status), .rd_req_out(rd_req), .rd_ram_out(rd_ram), .rd_addr_out(rd_addr),
        .rd_data_in(rd_data), .dgram_valid_out(dv), .dgram_ready_in(ready),
        .dgram_data_out(dd), .dgram_overrun_out(ovr), .step_clock_prescaler_out(presc));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude();
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    always @(posedge mclk_in) begin
        cycles++;
        if (dv && ready) got.push_back(dd);
        if (rd_req) begin
            n_req++;
            req_tag = {rd_ram, rd_addr};
        end
        if (ovr) n_ovr++;
        // Output may not move within four clocks of a serial clock fall
        if (!cs_n && !prev_cs) chk(32'(since_fall < 4 && sdo !== prev_out), 0);
        since_fall = (prev_sclk && !sclk) ? 0 : since_fall + 1;
        prev_sclk = sclk;
        prev_out = sdo;
        prev_cs = cs_n;
        if (cycles == 30000) begin
            fails++;
            conclude();
        end
    end

    task automatic t_reset();
        host_u.clks(2);
        chk(presc, 4'hF);
        chk({dv, ovr, rd_req}, 0);
        chk(sdo, 1);
        host_u.clks(2);
        sys_rst_in = 1'b0;
        host_u.clks(4);
    endtask : t_reset

    task automatic t_idle_irq();
        irq_n = 1'b0;
        host_u.clks(3);
        chk(sdo, 0);
        irq_n = 1'b1;
        host_u.clks(3);
        chk(sdo, 1);
    endtask : t_idle_irq

    task automatic t_write(input logic [5:0] addr, input logic [23:0] data, input int nbits);
        logic [31:0] tx;
        tx = {1'b0, addr, 1'b0, data};
        host_u.xfer(tx, nbits, rx);
        host_u.clks(12);
        if (nbits >= 32) begin
            // Beyond the 32-bit reply the output carries zeros
            chk(rx, 32'({status, 24'h000000} << (nbits - 32)));
            chk(got.size(), 1);
            chk(got.pop_front(), tx);
        end else begin
            chk(got.size(), 0);
        end
        chk(n_req, 0);
    endtask : t_write

    task automatic t_read(input logic ram, input logic [5:0] addr, input logic [23:0] word);
        logic [31:0] tx;
        tx = {ram, addr, 1'b1, 24'h000000};
        rd_data = word;
        status = word[23:16];
        irq_n = 1'b0;
        n_req = 0;
        host_u.xfer(tx, 32, rx);
        host_u.clks(12);
        chk(rx, {status, word});
        chk(n_req, 1);
        chk(req_tag, {ram, addr});
        chk(sdo, 0);
        chk(got.pop_front(), tx);
        irq_n = 1'b1;
        n_req = 0;
    endtask : t_read

    task automatic t_fill();
        ready = 1'b0;
        n_ovr = 0;
        for (int k = 0; k < 7; k++) begin
            host_u.xfer({8'h0A, 24'(k)}, 32, rx);
        end
        host_u.clks(12);
        chk(n_ovr, 1);
        ready = 1'b1;
        host_u.clks(20);
        chk(got.size(), 6);
        chk(got[0], 32'h0A000000);
        chk(got[5], 32'h0A000005);
        got.delete();
    endtask : t_fill

    initial begin
        irq_n = 1'b1;
        ready = 1'b1;
        status = 8'h5A;
        rd_data = 24'h000000;
        t_reset();
        t_idle_irq();
        t_write(PRESC_ADDR_DEFAULT, 24'h00000A, 32);
        chk(presc, 4'hA);
        t_read(1'b1, 6'h3F, 24'hC3A51E);
        t_read(1'b0, 6'h00, 24'h3C5AE1);
        t_write(PRESC_ADDR_DEFAULT, 24'h000005, 16);
        chk(presc, 4'hA);
        t_write(PRESC_ADDR_DEFAULT, 24'h000006, 40);
        chk(presc, 4'h6);
        t_fill();
        conclude();
    end
endmodule : tb_shdp_port
